// ==== hw/pfo_pkg.sv ====
package pfo_pkg;

    // ------------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_FLTCTRL = 8'h04;
    localparam logic [7:0] ADDR_FLTSTAT = 8'h08;
    localparam logic [7:0] ADDR_CHCFG   = 8'h0c;
    localparam logic [7:0] ADDR_INIT    = 8'h10;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    // ctrl: [0] enhanced_feature_enable, [2:1] fault_mode_field, [3] pair_fault_enable,
    //       [4] fault_irq_enable, [5] complementary, [6] deadtime_enable
    localparam int CTRL_FEN  = 0;
    localparam int CTRL_FM   = 1;
    localparam int CTRL_PFE  = 3;
    localparam int CTRL_FIE  = 4;
    localparam int CTRL_COMP = 5;
    localparam int CTRL_DEADTIME_ENABLE = 6;
    // fltctrl: [3:0] input enable, [7:4] filter enable, [11:8] filter value, [15:12] polarity
    localparam int FC_IEN = 0;
    localparam int FC_FEN = 4;
    localparam int FC_VAL = 8;
    localparam int FC_POL = 12;
    // fltstat: [3:0] per-input flags, [4] any flag (ro), [5] filtered level (ro)
    localparam int FS_ANY = 4;
    localparam int FS_LVL = 5;
    // chcfg: [5:0] mask, [13:8] polarity, [21:16] match trigger enable
    localparam int CC_MASK = 0;
    localparam int CC_POL  = 8;
    localparam int CC_TRG  = 16;
    // init: [5:0] initial values, [8] force (write one, self-clearing)
    localparam int IN_VAL = 0;
    localparam int IN_GO  = 8;

    // ------------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0]  FM_OFF   = 2'h0;
    localparam logic [1:0]  FM_AUTO  = 2'h3;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        PFO_BUS_IDLE  = 2'b00,
        PFO_BUS_WRITE = 2'b01,
        PFO_BUS_READ  = 2'b10
    } pfo_bus_t;

    typedef struct packed {
        logic [5:0] pwm;
        logic       cycle_start;
    } pfo_pwm_in_t;

endpackage

// ==== hw/pfo_top.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - masked channel output goes to its inactive level set by polarity.
// - fault control works only with enhanced enable and nonzero fault mode.
// - four fault inputs, each with input and filter enable, one shared value.
// - every fault input is synchronised to the system clock first.
// - state change restarts a 5-bit counter; accept once count reaches value.
// - input reverting before acceptance resets counter; glitches are dropped.
// - unfiltered path: flag set on third edge after input rises.
// - filtered path: flag set four plus filter value edges after rising.
// - rising edge on enabled input sets its flag; any-flag is OR of four.
// - active fault with pair fault enable forces outputs to polarity bits.
// - interrupt while any-flag and irq enable; cleared by writing zero, no read needed.
// - automatic mode releases outputs when level is zero and cycle starts.
// - manual modes release outputs when flags clear and a cycle starts.
// - fault polarity zero means high is fault; one means low is fault.
// - channel polarity zero means high active; one means low active.
// - writing one to force control drives outputs to initial values.
// - independent mode: each channel takes its own initial value.
// - complementary or deadtime: odd channel takes inverse of even value.
// - enabled channels pulse a trigger when counter equals compare value.
module pfo_top
    import pfo_pkg::*;
#(
    parameter int NCH  = 6,
    parameter int NFLT = 4,
    parameter int CW   = 16
)(
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic [NFLT-1:0]      fault_in,
    input  wire pfo_pwm_in_t          pwm_in,
    input  wire logic [CW-1:0]        counter,
    input  wire logic [NCH*CW-1:0]    compare,
    output logic      [NCH-1:0]       chan_out,
    output logic      [NCH-1:0]       match_trig,
    output logic                      fault_irq
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        pfo_bus_t           bus;
        logic [7:0]         addr;
        logic [7:0]         ctrl;
        logic [15:0]        fltctrl;
        logic [21:0]        chcfg;
        logic [5:0]         initv;
        logic               init_act;
        logic [NFLT-1:0]    sync1;
        logic [NFLT-1:0]    sync2;
        logic [NFLT-1:0]    filt;
        logic [NFLT*5-1:0]  cnt;
        logic [NFLT-1:0]    prev;
        logic [NFLT-1:0]    flag;
        logic               forced;
        logic [NCH-1:0]     out;
    } pfo_state_t;

    pfo_state_t st_ff;
    pfo_state_t nxt_st;

    function automatic logic [31:0] pfo_read(input pfo_state_t s, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            ADDR_CTRL:    r[7:0] = s.ctrl;
            ADDR_FLTCTRL: r[15:0] = s.fltctrl;
            ADDR_FLTSTAT:
            begin
                r[NFLT-1:0] = s.flag;
                r[FS_ANY]   = |s.flag;
                r[FS_LVL]   = |s.filt;
            end
            ADDR_CHCFG:   r[21:0] = s.chcfg;
            ADDR_INIT:    r[5:0] = s.initv;
            default:      r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    logic [1:0]      fmode;
    logic            fctl_on;
    logic [3:0]      fval;
    logic [NFLT-1:0] act_lvl;
    logic [NFLT-1:0] rise;
    logic [NFLT-1:0] lvl;
    logic [NFLT-1:0] fset;
    logic [NCH-1:0]  pol;
    logic [NCH-1:0]  pair_out;
    logic [NCH-1:0]  init_out;
    logic            take;
    logic            wr_now;
    logic [31:0]     wd;

    assign fmode   = st_ff.ctrl[CTRL_FM +: 2];
    assign fctl_on = st_ff.ctrl[CTRL_FEN] && (fmode != FM_OFF);
    assign fval    = st_ff.fltctrl[FC_VAL +: 4];
    assign pol     = st_ff.chcfg[CC_POL +: NCH];
    assign take    = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign wr_now  = (st_ff.bus == PFO_BUS_WRITE);
    assign wd      = hwdata;

    always_comb
    begin
        nxt_st = st_ff;
        // --------------------------------------------------------------
        // bus slave: zero wait states
        // --------------------------------------------------------------
        nxt_st.bus = take ? (hwrite ? PFO_BUS_WRITE : PFO_BUS_READ) : PFO_BUS_IDLE;
        if (take)
        begin
            nxt_st.addr = haddr[7:0];
        end
        nxt_st.init_act = 1'b0;
        if (wr_now)
        begin
            case (st_ff.addr)
                ADDR_CTRL:    nxt_st.ctrl = wd[7:0];
                ADDR_FLTCTRL: nxt_st.fltctrl = wd[15:0];
                ADDR_CHCFG:   nxt_st.chcfg = wd[21:0];
                ADDR_INIT:
                begin
                    nxt_st.initv    = wd[5:0];
                    nxt_st.init_act = wd[IN_GO];
                end
                default:      nxt_st.ctrl = st_ff.ctrl;
            endcase
        end

        // --------------------------------------------------------------
        // fault input path
        // --------------------------------------------------------------
        nxt_st.sync1 = fault_in;
        nxt_st.sync2 = st_ff.sync1;
        act_lvl = st_ff.sync2 ^ st_ff.fltctrl[FC_POL +: NFLT];
        for (int i = 0; i < NFLT; i++)
        begin
            if (st_ff.fltctrl[FC_FEN + i] && (fval != 4'h0))
            begin
                // counter restarts whenever the level agrees with the filtered state, so short pulses die here
                if (act_lvl[i] == st_ff.filt[i])
                begin
                    nxt_st.cnt[i*5 +: 5] = 5'h00;
                end
                // accept on the edge where the count would pass the value
                else if (st_ff.cnt[i*5 +: 5] >= {1'b0, fval})
                begin
                    nxt_st.filt[i]       = act_lvl[i];
                    nxt_st.cnt[i*5 +: 5] = 5'h00;
                end
                else
                begin
                    nxt_st.cnt[i*5 +: 5] = st_ff.cnt[i*5 +: 5] + 5'h01;
                end
                lvl[i] = st_ff.filt[i];
            end
            else
            begin
                nxt_st.cnt[i*5 +: 5] = 5'h00;
                nxt_st.filt[i]       = act_lvl[i];
                // bypass adds no stage, so the flag lands on the third edge
                lvl[i] = act_lvl[i];
            end
        end
        nxt_st.prev = lvl;
        rise = lvl & ~st_ff.prev;

        // --------------------------------------------------------------
        // flags: set wins over software clear
        // --------------------------------------------------------------
        for (int i = 0; i < NFLT; i++)
        begin
            if (wr_now && (st_ff.addr == ADDR_FLTSTAT) && !wd[i])
            begin
                nxt_st.flag[i] = 1'b0;
            end
            fset[i] = fctl_on && st_ff.fltctrl[FC_IEN + i] && rise[i];
            if (fset[i])
            begin
                nxt_st.flag[i] = 1'b1;
            end
        end

        // --------------------------------------------------------------
        // safe-state forcing and release
        // --------------------------------------------------------------
        // a new fault event forces; a flag left set must not re-force after auto release
        if (fctl_on && st_ff.ctrl[CTRL_PFE] && (|fset))
        begin
            nxt_st.forced = 1'b1;
        end
        else if (st_ff.forced && pwm_in.cycle_start)
        begin
            if (fmode == FM_AUTO)
            begin
                nxt_st.forced = |(st_ff.filt & st_ff.fltctrl[FC_IEN +: NFLT]);
            end
            else
            begin
                nxt_st.forced = |st_ff.flag;
            end
        end
        if (!fctl_on || !st_ff.ctrl[CTRL_PFE])
        begin
            nxt_st.forced = 1'b0;
        end

        // --------------------------------------------------------------
        // output conditioning
        // --------------------------------------------------------------
        for (int p = 0; p < NCH; p += 2)
        begin
            if (st_ff.ctrl[CTRL_COMP] || st_ff.ctrl[CTRL_DEADTIME_ENABLE])
            begin
                init_out[p]   = st_ff.initv[p];
                init_out[p+1] = ~st_ff.initv[p];
            end
            else
            begin
                init_out[p]   = st_ff.initv[p];
                init_out[p+1] = st_ff.initv[p+1];
            end
        end
        for (int c = 0; c < NCH; c++)
        begin
            // active-high internal level mapped to pin by polarity
            pair_out[c] = pwm_in.pwm[c] ^ pol[c];
            if (st_ff.chcfg[CC_MASK + c])
            begin
                pair_out[c] = pol[c];
            end
            if (st_ff.forced)
            begin
                pair_out[c] = pol[c];
            end
        end
        // init is a one-shot load; on the following edge the output returns to pair_out
        nxt_st.out = st_ff.init_act ? init_out : pair_out;
        if (st_ff.init_act)
        begin
            nxt_st.out = init_out;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = (st_ff.bus == PFO_BUS_READ) ? pfo_read(st_ff, st_ff.addr) : 32'h0000_0000;
    assign chan_out  = st_ff.out;
    assign fault_irq = (|st_ff.flag) && st_ff.ctrl[CTRL_FIE];

    always_comb
    begin
        for (int c = 0; c < NCH; c++)
        begin
            // combinational so the pulse lands in the match cycle itself
            match_trig[c] = st_ff.chcfg[CC_TRG + c] &&
                            (counter == compare[c*CW +: CW]);
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    unfilt_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (fctl_on && st_ff.fltctrl[0] && !st_ff.fltctrl[FC_FEN] && !st_ff.fltctrl[FC_POL]
         && $stable(st_ff.fltctrl) && $stable(st_ff.ctrl) && !wr_now
         && $rose(fault_in[0])) ##1 (!wr_now)[*2] |=> st_ff.flag[0])
        else $error("unfiltered fault flag late");
    irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (fault_irq && !wr_now) |=> fault_irq)
        else $error("irq dropped without software action");
    any_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.bus == PFO_BUS_READ && st_ff.addr == ADDR_FLTSTAT)
        |-> hrdata[FS_ANY] == |hrdata[NFLT-1:0])
        else $error("any flag not OR");
    fault_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !fctl_on |=> $stable(st_ff.flag) || $fell(|st_ff.flag) || !(|st_ff.flag))
        else $error("flag set with fault control off");
    safe_force_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.forced && !st_ff.init_act) |=> chan_out == $past(pol))
        else $error("forced output wrong");
    mask_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!st_ff.init_act && st_ff.chcfg[CC_MASK]) |=> chan_out[0] == $past(pol[0]))
        else $error("masked output wrong");
    init_comp_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.init_act && st_ff.ctrl[CTRL_COMP]) |=> chan_out[1] == !chan_out[0])
        else $error("init complement wrong");
    glitch_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.fltctrl[FC_FEN] && fval != 4'h0 && act_lvl[0] == st_ff.filt[0])
        |=> st_ff.cnt[4:0] == 5'h00)
        else $error("filter counter not reset");
    trig_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!st_ff.chcfg[CC_TRG]) |-> !match_trig[0])
        else $error("trigger without enable");

    // ------------------------------------------------------------------
    // checks: fault path
    // ------------------------------------------------------------------
    sync_delay_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st_ff.sync2 == $past(fault_in, 2))
        else $error("fault synchroniser delay wrong");
    filt_accept_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.fltctrl[FC_FEN] && fval != 4'h0 && act_lvl[0] != st_ff.filt[0]
         && st_ff.cnt[4:0] >= {1'b0, fval}) |=> st_ff.filt[0] == $past(act_lvl[0]))
        else $error("filter did not accept stable level");
    no_flag_dis_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!st_ff.fltctrl[FC_IEN] && !st_ff.flag[0]) |=> !st_ff.flag[0])
        else $error("flag set on disabled input");
    flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (fctl_on && st_ff.fltctrl[FC_IEN] && rise[0]) |=> st_ff.flag[0])
        else $error("fault edge did not set flag");
    flag_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_now && st_ff.addr == ADDR_FLTSTAT && !wd[0] && !rise[0]) |=> !st_ff.flag[0])
        else $error("flag not cleared by write of zero");
    force_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (fctl_on && st_ff.ctrl[CTRL_PFE] && (|fset)) |=> st_ff.forced)
        else $error("fault event did not force outputs");
    manual_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.forced && fctl_on && st_ff.ctrl[CTRL_PFE] && fmode != FM_AUTO
         && (|st_ff.flag)) |=> st_ff.forced)
        else $error("manual mode released with flags set");
    auto_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.forced && pwm_in.cycle_start && fmode == FM_AUTO && !(|fset)
         && !(|(st_ff.filt & st_ff.fltctrl[FC_IEN +: NFLT]))) |=> !st_ff.forced)
        else $error("auto mode did not release outputs");

    // ------------------------------------------------------------------
    // checks: outputs and triggers
    // ------------------------------------------------------------------
    out_polarity_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!st_ff.init_act && !st_ff.forced && !st_ff.chcfg[CC_MASK])
        |=> chan_out[0] == ($past(pwm_in.pwm[0]) ^ $past(pol[0])))
        else $error("polarity mapping wrong");
    init_indep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.init_act && !st_ff.ctrl[CTRL_COMP] && !st_ff.ctrl[CTRL_DEADTIME_ENABLE])
        |=> chan_out == $past(st_ff.initv))
        else $error("independent init wrong");
    irq_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_now && st_ff.addr == ADDR_CTRL && !wd[CTRL_FIE]) |=> !fault_irq)
        else $error("irq stayed after enable cleared");
    trig_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff.chcfg[CC_TRG + 2] && counter == compare[2*CW +: CW]) |-> match_trig[2])
        else $error("enabled match gave no trigger");

endmodule

// ==== dv/pfo_far_end.sv ====
`timescale 1ns/1ps
module pfo_far_end (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [3:0] fault_cmd,
    input  wire logic [5:0] match_trig,
    output logic      [3:0] fault_in,
    output int              trig_count
);
    // ------------------------------------------------------------------
    // plant fault pins and trigger consumers
    // ------------------------------------------------------------------
    // fault pins are driven levels with no pull, so they simply follow the plant
    assign fault_in = fault_cmd;
    // consumers count every asserted trigger bit in each cycle, several per period allowed
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            trig_count <= 0;
        else
            trig_count <= trig_count + $countones(match_trig);
endmodule

// ==== dv/test_pwm_pair_fault_output_control.sv ====
`timescale 1ns/1ps
module test_pwm_pair_fault_output_control;
    import pfo_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, fault_irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  fault_cmd, fault_in;
    logic [15:0] counter;
    logic [95:0] compare;
    logic [5:0]  chan_out, match_trig;
    wire         hready = hreadyout;
    pfo_pwm_in_t pwm_in;
    int          fail_count, cmp_count, trig_count;
    // pwm, polarity, mask, expected pin levels
    logic [31:0] rows [5] = '{32'h3f00003f, 32'h3f3f0000, 32'h150f001a,
                              32'h3f053309, 32'h00300c30};

    pfo_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .fault_in(fault_in), .pwm_in(pwm_in), .counter(counter), .compare(compare),
        .chan_out(chan_out), .match_trig(match_trig), .fault_irq(fault_irq));
    pfo_far_end far_u (.hclk(hclk), .hresetn(hresetn), .fault_cmd(fault_cmd),
        .match_trig(match_trig), .fault_in(fault_in), .trig_count(trig_count));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // hready is sampled at each falling edge of hclk
    task automatic wait_ready;
        int n;
        n = 0;
        do
        begin
            @(negedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            fail_count++;
            summarize();
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= {24'h0, a};
        hwrite <= w;
        wait_ready();
        @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
        @(posedge hclk);
        #1;
    endtask

    task automatic wait_out(input logic [5:0] exp);
        int n;
        n = 0;
        while (chan_out !== exp && n < 8)
        begin
            @(posedge hclk);
            #1;
            n++;
        end
        check("chan_out", {26'h0, chan_out}, {26'h0, exp});
    endtask

    task automatic cyc;
        @(posedge hclk);
        pwm_in.cycle_start <= 1'b1;
        @(posedge hclk);
        pwm_in.cycle_start <= 1'b0;
        #1;
    endtask

    task automatic edges(input int n, input logic [5:0] exp);
        repeat (n) @(posedge hclk);
        #1;
        check("chan_out", {26'h0, chan_out}, {26'h0, exp});
    endtask

    // ------------------------------------------------------------------
    // clock and stimulus
    // ------------------------------------------------------------------
    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    initial
    begin
        {hresetn, hsel, hwrite, haddr, hwdata, htrans, fault_cmd, counter} = '0;
        hsize  = 3'h2;
        pwm_in = '0;
        for (int c = 0; c < 6; c++)
            compare[c*16 +: 16] = 16'(c * 16);
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        check("chan_out", {26'h0, chan_out}, 32'h0);
        check("fault_irq", {31'h0, fault_irq}, 32'h0);
        for (int a = 0; a <= 'h14; a += 4)
        begin
            ahb(1'b0, 8'(a), 32'h0);
            check("reg", rd, RST_WORD);
        end
        for (int i = 0; i < 5; i++)
        begin
            ahb(1'b1, ADDR_CHCFG, {16'h0, rows[i][23:16], rows[i][15:8]});
            @(posedge hclk);
            pwm_in.pwm <= rows[i][29:24];
            edges(2, rows[i][5:0]);
        end
        ahb(1'b1, ADDR_CHCFG, 32'h0);
        pwm_in.pwm <= 6'h3f;
        ahb(1'b1, ADDR_FLTCTRL, 32'h1);
        ahb(1'b1, ADDR_CTRL, 32'h1);
        fault_cmd <= 4'h1;
        edges(6, 6'h3f);
        ahb(1'b0, ADDR_FLTSTAT, 32'h0);
        check("flags", rd & 32'h3f, 32'h20);
        fault_cmd <= 4'h0;
        ahb(1'b1, ADDR_CTRL, 32'h1b);
        @(posedge hclk);
        fault_cmd <= 4'h1;
        edges(3, 6'h3f);
        edges(1, 6'h00);
        check("fault_irq", {31'h0, fault_irq}, 32'h1);
        ahb(1'b0, ADDR_FLTSTAT, 32'h0);
        check("flags", rd & 32'h1f, 32'h11);
        fault_cmd <= 4'h0;
        repeat (4) @(posedge hclk);
        cyc();
        wait_out(6'h00);
        ahb(1'b1, ADDR_FLTSTAT, 32'h0);
        check("fault_irq", {31'h0, fault_irq}, 32'h0);
        edges(2, 6'h00);
        cyc();
        wait_out(6'h3f);
        ahb(1'b1, ADDR_FLTCTRL, 32'h311);
        @(posedge hclk);
        fault_cmd <= 4'h1;
        edges(7, 6'h3f);
        edges(1, 6'h00);
        ahb(1'b1, ADDR_CTRL, 32'h1f);
        cyc();
        wait_out(6'h00);
        fault_cmd <= 4'h0;
        repeat (10) @(posedge hclk);
        cyc();
        wait_out(6'h3f);
        ahb(1'b1, ADDR_FLTSTAT, 32'h0);
        @(posedge hclk);
        fault_cmd <= 4'h1;
        repeat (2) @(posedge hclk);
        fault_cmd <= 4'h0;
        edges(12, 6'h3f);
        ahb(1'b0, ADDR_FLTSTAT, 32'h0);
        check("flags", rd & 32'h1f, 32'h0);
        ahb(1'b1, ADDR_CTRL, 32'h1b);
        fault_cmd <= 4'h1;
        ahb(1'b1, ADDR_FLTCTRL, 32'h1001);
        edges(4, 6'h3f);
        fault_cmd <= 4'h0;
        wait_out(6'h00);
        fault_cmd <= 4'h1;
        repeat (4) @(posedge hclk);
        ahb(1'b1, ADDR_FLTSTAT, 32'h0);
        cyc();
        wait_out(6'h3f);
        // init with the counter stopped and no output control, first independent, then complementary
        ahb(1'b1, ADDR_CTRL, 32'h0);
        pwm_in.pwm <= 6'h00;
        fault_cmd  <= 4'h0;
        ahb(1'b1, ADDR_INIT, 32'h116);
        wait_out(6'h16);
        wait_out(6'h00);
        ahb(1'b1, ADDR_CTRL, 32'h20);
        ahb(1'b1, ADDR_INIT, 32'h105);
        wait_out(6'h25);
        ahb(1'b1, ADDR_CHCFG, 32'h000c0000);
        for (int i = 1; i < 5; i++)
        begin
            @(posedge hclk);
            counter <= 16'(i * 16);
            #1;
            if (i == 2)
                check("match_trig", {26'h0, match_trig}, 32'h4);
        end
        @(posedge hclk);
        counter <= 16'h0;
        repeat (2) @(posedge hclk);
        #1;
        check("trig_count", 32'(trig_count), 32'h2);
        summarize();
    end
endmodule
